/* hw/icm_pkg.sv */
// Constants, register map and mode codes of the clock mode controller.
// Assumes a single 20 MHz bus clock and an AXI4-Lite register port.
`default_nettype none
package icm_pkg;
    // ------------------------------------------------------------------
    // Register map (byte addresses)
    // ------------------------------------------------------------------
    localparam logic [4:0] OFF_TRIM = 5'h00;
    localparam logic [4:0] OFF_STATUS = 5'h04;
    localparam logic [4:0] OFF_CTRL1 = 5'h08;
    localparam logic [4:0] OFF_CTRL2 = 5'h0C;
    // Control 1: source select 7:6, divider 5:3, ref select 2,
    // int ref out enable 1, int ref stop keep 0
    localparam int CLOCK_SOURCE_SELECT_LSB = 6;
    localparam int REFERENCE_DIVIDER_LSB = 3;
    localparam int IREF_SEL_BIT = 2;
    localparam int IREF_OE_BIT = 1;
    localparam int IREF_KEEP_BIT = 0;
    // Control 2: loop low power 3, osc request 2, ext out enable 1,
    // ext stop keep 0
    localparam int LP_BIT = 3;
    localparam int OSC_REQ_BIT = 2;
    localparam int EREF_OE_BIT = 1;
    localparam int EREF_KEEP_BIT = 0;
    // Status: ref source 4, mode 3:2, osc init 1, fine trim 0
    localparam int REF_ST_BIT = 4;
    localparam int MODE_ST_LSB = 2;
    localparam int OSC_DONE_BIT = 1;
    localparam int FINE_BIT = 0;
    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    localparam logic [7:0] CTRL1_RESET = 8'h04;
    localparam logic [7:0] CTRL2_RESET = 8'h00;
    localparam logic [7:0] TRIM_RESET = 8'h80;
    localparam logic [1:0] AXI_OKAY = 2'h0;
    localparam logic [1:0] AXI_SLVERR = 2'h2;
    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam longint MCLK_HZ = 20_000_000;
    localparam longint REF_MIN_MILLIHZ = 31_250_000;
    localparam longint REF_MAX_MILLIHZ = 39_062_500;
    // Divided reference period window in bus cycles (512..640)
    localparam logic [9:0] LOCK_MAX_CYC =
        10'(MCLK_HZ * 1000 / REF_MIN_MILLIHZ);
    localparam logic [9:0] LOCK_MIN_CYC =
        10'((MCLK_HZ * 1000 + REF_MAX_MILLIHZ - 1) / REF_MAX_MILLIHZ);
    localparam logic [1:0] SWITCH_EDGES = 2'h3;
    localparam int OSC_INIT_EDGES = 4096;
    // ------------------------------------------------------------------
    // Clock source codes and modes
    // ------------------------------------------------------------------
    localparam logic [1:0] SRC_LOOP = 2'h0;
    localparam logic [1:0] SRC_INT = 2'h1;
    localparam logic [1:0] SRC_EXT = 2'h2;
    typedef enum logic [2:0] {
        MODE_ENG_INT = 3'b000,
        MODE_ENG_EXT = 3'b001,
        MODE_BYP_INT = 3'b010,
        MODE_BYP_INT_LP = 3'b011,
        MODE_BYP_EXT = 3'b100,
        MODE_BYP_EXT_LP = 3'b101,
        MODE_STOP = 3'b110
    } icm_mode_t;
endpackage
`default_nettype wire

/* hw/icm_sync.sv */
// Two flip-flop synchroniser for levels entering the bus clock domain.
// Assumes inputs change no faster than a quarter of the bus clock.
`default_nettype none
module icm_sync #(
    parameter int WIDTH = 2
) (
    input wire logic mclk,
    input wire logic reset,
    input wire logic [WIDTH-1:0] async,
    output logic [WIDTH-1:0] synced
);
    logic [WIDTH-1:0] stage1;

    always_ff @(posedge mclk)
    begin
        if (reset)
        begin
            stage1 <= '0;
            synced <= '0;
        end
        else
        begin
            stage1 <= async;
            synced <= stage1;
        end
    end
endmodule // icm_sync
`default_nettype wire

/* hw/icm_clock_mode_ctrl.sv */
// Clock source mode controller: trim, status, seven-state mode machine
// and clock gating selects, with an AXI4-Lite register port.
// Assumes reference clock pins are free-running and slower than mclk/4.
//
// Function
// R1: Eight-bit period trim drives the reference period, binary weighted.
// R2: Fine trim bit is the least significant step of period trim.
// R3: Reference source status follows select after synchronised switch.
// R4: Mode status reports applied mode after synchronised switch.
// R5: Osc init done sets after init edges when requested and needed.
// R6: Osc init done clears only when ext enable or request clears.
// R7: Status bits 7:5 read zero; software writes them as zero.
// R8: Seven states; moves only between permitted modes.
// R9: Engaged internal is the reset mode, with source 00, internal.
// R10: Engaged modes use loop output, debug clock and reference on.
// R11: Engaged external needs source 00, external, ref in lock range.
// R12: Bypass internal: source 01, internal, debug or not low power.
// R13: Bypass internal low power: loop off, debug clock off.
// R14: Bypass external: source 10, external, debug or not low power.
// R15: Bypass external low power: loop off, debug clock off.
// R16: Stop makes outputs static; int ref runs if enabled and kept.
// R17: In stop ext ref runs only if enabled and kept.
// R18: Software changes divider with reference select in one write.
// R19: Reference switch completes after a few new divided edges.
// R20: Source select 11 acts as 00.
// R21: Divider divides selected reference by two to its value.
// R22: Loop low power disables loop in bypass unless debug active.
// R23: Reference status crosses through two flip-flops first.
//
// Decided for this implementation: the placing of the registers and the AXI4-Lite slave port.
`default_nettype none
module icm_clock_mode_ctrl
    import icm_pkg::*;
#(
    parameter int OSC_EDGES = OSC_INIT_EDGES
) (
    input wire logic mclk,
    input wire logic reset,
    input wire logic [4:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [4:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic intRefClk,
    input wire logic extRefClk,
    input wire logic stopRequest,
    input wire logic debugModeActive,
    output logic [8:0] trimCode,
    output logic [2:0] refDivider,
    output logic loopRefInternal,
    output logic loopEnable,
    output logic [1:0] mainClockSelect,
    output logic mainClockEnable,
    output logic debugLinkClockEnable,
    output logic intRefClockEnable,
    output logic extRefClockEnable,
    output logic [2:0] modeState
);
    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    logic [7:0] periodTrim, ctrl1, ctrl2;
    logic finePeriodTrim, oscInitDone, refSourceStatus;
    logic [1:0] clockModeStatus;
    icm_mode_t state, next_state;
    logic awHeld, wHeld;
    logic [4:0] awAddrQ;
    logic [7:0] wDataQ;
    logic wStrbQ;
    logic doWrite;

    assign s_axi_awready = !awHeld && !s_axi_bvalid;
    assign s_axi_wready = !wHeld && !s_axi_bvalid;
    assign s_axi_arready = !s_axi_rvalid;
    assign doWrite = awHeld && wHeld && !s_axi_bvalid;

    always_ff @(posedge mclk)
    begin
        if (reset)
        begin
            awHeld <= 1'b0;
            wHeld <= 1'b0;
            awAddrQ <= '0;
            wDataQ <= '0;
            wStrbQ <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= AXI_OKAY;
        end
        else
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                awHeld <= 1'b1;
                awAddrQ <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                wHeld <= 1'b1;
                wDataQ <= s_axi_wdata[7:0];
                wStrbQ <= s_axi_wstrb[0];
            end
            if (doWrite)
            begin
                awHeld <= 1'b0;
                wHeld <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= (awAddrQ > OFF_CTRL2 || awAddrQ[1:0] != 2'h0)
                    ? AXI_SLVERR : AXI_OKAY;
            end
            else if (s_axi_bready)
                s_axi_bvalid <= 1'b0;
        end
    end

    logic wrTrim, wrStatus;
    assign wrTrim = doWrite && wStrbQ && awAddrQ == OFF_TRIM;
    assign wrStatus = doWrite && wStrbQ && awAddrQ == OFF_STATUS;

    // Trim is not restored by a warm reset in the real part; here it
    // takes a plain default so simulation starts defined.
    always_ff @(posedge mclk)
    begin
        if (reset)
        begin
            periodTrim <= TRIM_RESET;
            finePeriodTrim <= 1'b0;
            ctrl1 <= CTRL1_RESET;
            ctrl2 <= CTRL2_RESET;
        end
        else
        begin
            if (wrTrim)
                periodTrim <= wDataQ; // [R1]
            if (wrStatus)
                finePeriodTrim <= wDataQ[FINE_BIT]; // [R2]
            // Divider and reference select land in one write
            if (doWrite && wStrbQ && awAddrQ == OFF_CTRL1)
                ctrl1 <= wDataQ;
            if (doWrite && wStrbQ && awAddrQ == OFF_CTRL2)
                ctrl2 <= wDataQ & 8'h0F;
        end
    end

    logic [7:0] statusRead;
    assign statusRead = {3'b000, refSourceStatus, clockModeStatus, // [R7]
                         oscInitDone, finePeriodTrim};

    always_ff @(posedge mclk)
    begin
        if (reset)
        begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= AXI_OKAY;
        end
        else if (s_axi_arvalid && s_axi_arready)
        begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= AXI_OKAY;
            s_axi_rdata <= 32'h0000_0000;
            if (s_axi_araddr[1:0] != 2'h0)
                s_axi_rresp <= AXI_SLVERR;
            else
                unique case (s_axi_araddr)
                    OFF_TRIM: s_axi_rdata[7:0] <= periodTrim;
                    OFF_STATUS: s_axi_rdata[7:0] <= statusRead;
                    OFF_CTRL1: s_axi_rdata[7:0] <= ctrl1;
                    OFF_CTRL2: s_axi_rdata[7:0] <= ctrl2;
                    default: s_axi_rresp <= AXI_SLVERR;
                endcase
        end
        else if (s_axi_rready)
            s_axi_rvalid <= 1'b0;
    end

    // ------------------------------------------------------------------
    // Control fields
    // ------------------------------------------------------------------
    logic [1:0] srcSelect;
    logic intRefSelect, lowPower, extOscRequest, extRefOutEn;
    assign srcSelect = (ctrl1[CLOCK_SOURCE_SELECT_LSB+:2] == 2'h3)
        ? SRC_LOOP : ctrl1[CLOCK_SOURCE_SELECT_LSB+:2]; // [R20]
    assign refDivider = ctrl1[REFERENCE_DIVIDER_LSB+:3];
    assign intRefSelect = ctrl1[IREF_SEL_BIT];
    assign lowPower = ctrl2[LP_BIT] && !debugModeActive; // [R22]
    assign extOscRequest = ctrl2[OSC_REQ_BIT];
    assign extRefOutEn = ctrl2[EREF_OE_BIT];
    assign trimCode = {periodTrim, finePeriodTrim}; // [R1] [R2]

    // ------------------------------------------------------------------
    // Reference edges and divided reference
    // ------------------------------------------------------------------
    logic [1:0] refSync;
    logic [1:0] refPrev;
    logic intEdge, extEdge, loopRefEdge, divTick, inLockRange;
    logic [6:0] divCount, divLimit;
    logic [9:0] periodCount, lastPeriod;

    icm_sync #(.WIDTH(2)) u_ref_sync (
        .mclk(mclk),
        .reset(reset),
        .async({extRefClk, intRefClk}),
        .synced(refSync)
    ); // [R23]

    always_ff @(posedge mclk)
    begin
        if (reset)
            refPrev <= 2'b00;
        else
            refPrev <= refSync;
    end

    assign intEdge = refSync[0] && !refPrev[0];
    assign extEdge = refSync[1] && !refPrev[1];
    assign loopRefEdge = intRefSelect ? intEdge : extEdge;
    assign divLimit = 7'((8'h01 << refDivider) - 8'h01); // [R21]
    assign divTick = loopRefEdge && divCount >= divLimit;
    assign inLockRange = lastPeriod >= LOCK_MIN_CYC
        && lastPeriod <= LOCK_MAX_CYC;

    // Period of the divided reference decides if the loop can lock
    always_ff @(posedge mclk)
    begin
        if (reset)
        begin
            divCount <= '0;
            periodCount <= '0;
            lastPeriod <= '0;
        end
        else
        begin
            if (divTick)
                divCount <= '0;
            else if (loopRefEdge)
                divCount <= divCount + 7'h01;
            if (divTick)
            begin
                lastPeriod <= periodCount;
                periodCount <= '0;
            end
            else if (periodCount != 10'h3FF)
                periodCount <= periodCount + 10'h001;
        end
    end

    // ------------------------------------------------------------------
    // Synchronised status switching
    // ------------------------------------------------------------------
    logic [1:0] refSwitchCount, modeSwitchCount;
    logic modeEdge;
    always_comb
    begin
        unique case (srcSelect)
            SRC_INT: modeEdge = intEdge;
            SRC_EXT: modeEdge = extEdge;
            default: modeEdge = divTick;
        endcase
    end

    // A missing new clock never produces edges, so the old one stays
    always_ff @(posedge mclk)
    begin
        if (reset)
        begin
            refSourceStatus <= 1'b1;
            refSwitchCount <= '0;
        end
        else if (intRefSelect == refSourceStatus)
            refSwitchCount <= '0;
        else if (divTick)
        begin
            if (refSwitchCount == SWITCH_EDGES - 2'h1)
                refSourceStatus <= intRefSelect; // [R3] [R19]
            refSwitchCount <= refSwitchCount + 2'h1;
        end
    end

    always_ff @(posedge mclk)
    begin
        if (reset)
        begin
            clockModeStatus <= SRC_LOOP;
            modeSwitchCount <= '0;
        end
        else if (srcSelect == clockModeStatus)
            modeSwitchCount <= '0;
        else if (modeEdge)
        begin
            if (modeSwitchCount == SWITCH_EDGES - 2'h1)
                clockModeStatus <= srcSelect; // [R4]
            modeSwitchCount <= modeSwitchCount + 2'h1;
        end
    end

    // ------------------------------------------------------------------
    // Oscillator initialisation
    // ------------------------------------------------------------------
    logic [12:0] oscCount;
    logic extRefNeeded, oscClear, prevOscReq, prevExtOe, oscSet;
    assign extRefNeeded = extRefOutEn || state == MODE_ENG_EXT
        || state == MODE_BYP_EXT || state == MODE_BYP_EXT_LP;
    assign oscSet = extOscRequest && extRefNeeded
        && oscCount == 13'(OSC_EDGES);
    assign oscClear = (prevOscReq && !extOscRequest)
        || (prevExtOe && !extRefOutEn);

    always_ff @(posedge mclk)
    begin
        if (reset)
        begin
            oscCount <= '0;
            oscInitDone <= 1'b0;
            prevOscReq <= 1'b0;
            prevExtOe <= 1'b0;
        end
        else
        begin
            prevOscReq <= extOscRequest;
            prevExtOe <= extRefOutEn;
            if (!extOscRequest || !extRefNeeded)
                oscCount <= '0;
            else if (extEdge && oscCount != 13'(OSC_EDGES))
                oscCount <= oscCount + 13'h0001;
            // Set wins over a clear in the same cycle
            if (oscSet)
                oscInitDone <= 1'b1; // [R5]
            else if (oscClear)
                oscInitDone <= 1'b0; // [R6]
        end
    end

    // ------------------------------------------------------------------
    // Mode machine
    // ------------------------------------------------------------------
    always_comb
    begin
        next_state = state;
        if (stopRequest)
            next_state = MODE_STOP;
        else
            unique case (clockModeStatus) // [R8]
                SRC_INT:
                    if (refSourceStatus)
                        next_state = lowPower ? MODE_BYP_INT_LP
                                              : MODE_BYP_INT; // [R12] [R13]
                SRC_EXT:
                    if (!refSourceStatus)
                        next_state = lowPower ? MODE_BYP_EXT_LP
                                              : MODE_BYP_EXT; // [R14] [R15]
                default:
                    if (refSourceStatus)
                        next_state = MODE_ENG_INT; // [R9]
                    else if (inLockRange)
                        next_state = MODE_ENG_EXT; // [R11]
            endcase
    end

    always_ff @(posedge mclk)
    begin
        if (reset)
            state <= MODE_ENG_INT; // [R9]
        else
            state <= next_state;
    end

    // ------------------------------------------------------------------
    // Clock selects and gates
    // ------------------------------------------------------------------
    logic inStop;
    assign inStop = state == MODE_STOP;
    always_ff @(posedge mclk)
    begin
        if (reset)
        begin
            loopEnable <= 1'b1;
            mainClockSelect <= SRC_LOOP;
            loopRefInternal <= 1'b1;
            intRefClockEnable <= 1'b0;
            extRefClockEnable <= 1'b0;
        end
        else
        begin
            loopRefInternal <= refSourceStatus;
            mainClockSelect <= clockModeStatus; // [R10]
            loopEnable <= next_state == MODE_ENG_INT
                || next_state == MODE_ENG_EXT
                || next_state == MODE_BYP_INT
                || next_state == MODE_BYP_EXT; // [R10] [R22]
            intRefClockEnable <= ctrl1[IREF_OE_BIT]
                && (next_state != MODE_STOP
                    || ctrl1[IREF_KEEP_BIT]); // [R16]
            extRefClockEnable <= extRefOutEn
                && (next_state != MODE_STOP
                    || ctrl2[EREF_KEEP_BIT]); // [R17]
        end
    end

    // Debug clock shares the loop; main clock stops with the machine
    assign debugLinkClockEnable = loopEnable;
    assign mainClockEnable = !inStop; // [R16]
    assign modeState = state;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    a_trim_write: assert property (@(posedge mclk) disable iff (reset) // [R1]
        wrTrim |=> trimCode[8:1] == $past(wDataQ))
        else $error("period trim not applied");
    a_fine_write: assert property (@(posedge mclk) disable iff (reset) // [R2]
        wrStatus |=> trimCode[0] == $past(wDataQ[0]))
        else $error("fine trim not applied");
    a_ref_switch: assert property (@(posedge mclk) disable iff (reset) // [R3]
        $changed(refSourceStatus) |-> $past(divTick)
            && refSourceStatus == $past(intRefSelect))
        else $error("reference status changed without switch edge");
    a_osc_set: assert property (@(posedge mclk) disable iff (reset) // [R5]
        $rose(oscInitDone) |-> $past(extOscRequest) && $past(extRefNeeded))
        else $error("osc init done set without request");
    a_osc_clear: assert property (@(posedge mclk) disable iff (reset) // [R6]
        $fell(oscInitDone) |-> $past(oscClear))
        else $error("osc init done cleared by wrong event");
    a_status_rsvd: assert property (@(posedge mclk) disable iff (reset) // [R7]
        s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h00_0000
            && ($past(s_axi_araddr) != OFF_STATUS
                || s_axi_rdata[7:5] == 3'b000))
        else $error("reserved read bits not zero");
    a_reset_mode: assert property (@(posedge mclk) // [R9]
        $past(reset) && !reset |-> state == MODE_ENG_INT
            && loopEnable && mainClockEnable)
        else $error("machine not in engaged internal after reset");
    a_lp_loop_off: assert property (@(posedge mclk) disable iff (reset) // [R13]
        (state == MODE_BYP_INT_LP || state == MODE_BYP_EXT_LP)
            |-> !loopEnable && !debugLinkClockEnable)
        else $error("loop running in low power bypass");
    a_stop_static: assert property (@(posedge mclk) disable iff (reset) // [R16]
        inStop |-> !mainClockEnable && !loopEnable
            && (!intRefClockEnable || $past(ctrl1[IREF_KEEP_BIT])))
        else $error("clock running in stop");
    a_stop_ext: assert property (@(posedge mclk) disable iff (reset) // [R17]
        inStop && $past(inStop) && $stable(ctrl2) |-> extRefClockEnable
            == (ctrl2[EREF_OE_BIT] && ctrl2[EREF_KEEP_BIT]))
        else $error("ext reference gate wrong in stop");
endmodule // icm_clock_mode_ctrl
`default_nettype wire

/* test/icm_clock_mode_ctrl_tb.sv */
// Self-checking bench for the clock mode controller.
// Assumes the design package and modules under hw/ are compiled first.
`default_nettype none
module icm_clock_mode_ctrl_tb
    import icm_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic mclk = 1'b0;
    logic reset = 1'b1;
    logic [4:0] awAddr = 5'h00, arAddr = 5'h00;
    logic awValid = 0, wValid = 0, bReady = 0, arValid = 0, rReady = 0;
    logic [31:0] wData = 32'h0000_0000;
    logic intRefClk = 0, extRefClk = 0, stopReq = 0, dbg = 0;
    wire logic awReady, wReady, bValid, arReady, rValid;
    wire logic [1:0] bResp, rResp, mainSel;
    wire logic [31:0] rData;
    wire logic [8:0] trimCode;
    wire logic [2:0] refDiv, modeState;
    wire logic loopRefInt, loopEn, mainEn, dbgEn, intEn, extEn;
    int error_cnt = 0, n_checks = 0, seed = 16405, i;
    logic [31:0] rd;
    logic [1:0] rr;
    logic [7:0] d;
    logic [4:0] addrs [5] = '{OFF_TRIM, OFF_STATUS, OFF_CTRL1, OFF_CTRL2,
        5'h14};
    logic [31:0] exps [5] = '{{24'h00_0000, TRIM_RESET}, 32'h0000_0010,
        {24'h00_0000, CTRL1_RESET}, {24'h00_0000, CTRL2_RESET}, 32'h0000_0000};
    // Reference pins run free and slower than a quarter of mclk
    always #200 intRefClk = ~intRefClk;
    always #230 extRefClk = ~extRefClk;
    initial
        forever #25 mclk = ~mclk;
    icm_clock_mode_ctrl #(.OSC_EDGES(8)) dut_u (.mclk(mclk), .reset(reset),
        .s_axi_awaddr(awAddr), .s_axi_awvalid(awValid),
        .s_axi_awready(awReady), .s_axi_wdata(wData), .s_axi_wstrb(4'hF),
        .s_axi_wvalid(wValid), .s_axi_wready(wReady), .s_axi_bresp(bResp),
        .s_axi_bvalid(bValid), .s_axi_bready(bReady), .s_axi_araddr(arAddr),
        .s_axi_arvalid(arValid), .s_axi_arready(arReady),
        .s_axi_rdata(rData), .s_axi_rresp(rResp), .s_axi_rvalid(rValid),
        .s_axi_rready(rReady), .intRefClk(intRefClk), .extRefClk(extRefClk),
        .stopRequest(stopReq), .debugModeActive(dbg), .trimCode(trimCode),
        .refDivider(refDiv), .loopRefInternal(loopRefInt),
        .loopEnable(loopEn), .mainClockSelect(mainSel),
        .mainClockEnable(mainEn), .debugLinkClockEnable(dbgEn),
        .intRefClockEnable(intEn), .extRefClockEnable(extEn),
        .modeState(modeState));
    // ------------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------------
    task automatic complete_run;
        $display("Checks %0d mismatches %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task automatic check(input string nm, input logic [31:0] seen, exp);
        n_checks++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic tmo(input int k);
        if (k >= 300)
        begin
            error_cnt++;
            $display("[ERR] wait expected done seen timeout");
            complete_run();
        end
    endtask
    function automatic logic [31:0] stExp(input logic r, input logic [1:0] m,
        input logic o, input logic f);
        return {27'h000_0000, r, m, o, f};
    endfunction
    // Address and data are offered together; each drops once taken
    task automatic axiWrite(input logic [4:0] a, input logic [7:0] v);
        bit aw;
        bit w;
        int k;
        aw = 0;
        w = 0;
        @(posedge mclk);
        awAddr <= a;
        wData <= {24'h00_0000, v};
        awValid <= 1'b1;
        wValid <= 1'b1;
        bReady <= 1'b1;
        for (k = 0; k < 300; k++)
        begin
            @(negedge mclk);
            if (bValid === 1'b1) break;
            aw = aw || (awReady === 1'b1);
            w = w || (wReady === 1'b1);
            @(posedge mclk);
            awValid <= !aw;
            wValid <= !w;
        end
        tmo(k);
        check("bresp", bResp, AXI_OKAY);
        @(posedge mclk);
        bReady <= 1'b0;
    endtask
    task automatic axiRead(input logic [4:0] a);
        bit t;
        int k;
        t = 0;
        @(posedge mclk);
        arAddr <= a;
        arValid <= 1'b1;
        rReady <= 1'b1;
        for (k = 0; k < 300; k++)
        begin
            @(negedge mclk);
            if (rValid === 1'b1) break;
            t = t || (arReady === 1'b1);
            @(posedge mclk);
            arValid <= !t;
        end
        tmo(k);
        rd = rData;
        rr = rResp;
        @(posedge mclk);
        rReady <= 1'b0;
    endtask
    task automatic waitMode(input logic [2:0] m);
        int k;
        for (k = 0; k < 3000 && modeState !== m; k++)
            @(posedge mclk);
        tmo(k / 10);
        // Outputs are registered from next_state, so they change on the same edge as the state
        repeat (2) @(posedge mclk);
        check("mode", modeState, m);
    endtask
    task automatic waitStatus(input logic [31:0] e);
        int k;
        for (k = 0; k < 300; k++)
        begin
            axiRead(OFF_STATUS);
            if (rd === e) break;
        end
        tmo(k);
        check("status", rd, e);
    endtask
    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial
    begin
        repeat (6) @(posedge mclk);
        reset <= 1'b0;
        @(posedge mclk);
        check("reset mode", modeState, MODE_ENG_INT);
        check("reset out", {loopEn, mainSel, loopRefInt}, 4'b1001);
        for (i = 0; i < 5; i++)
        begin
            axiRead(addrs[i]);
            check("reset read", rd, exps[i]);
            check("rresp", rr, (i == 4) ? AXI_SLVERR : AXI_OKAY);
        end
        $display("Test reset done");
        for (i = 0; i < 4; i++)
        begin
            d = (i == 0) ? 8'hFF : 8'($random(seed));
            axiWrite(OFF_TRIM, d);
            axiRead(OFF_TRIM);
            check("trim", {rd[7:0], trimCode[8:1]}, {d, d});
        end
        axiWrite(OFF_STATUS, 8'h1F);
        axiRead(OFF_STATUS);
        check("status wr", rd, stExp(1'b1, SRC_LOOP, 1'b0, 1'b1));
        check("fine set", trimCode[0], 1'b1);
        axiWrite(OFF_STATUS, 8'h00);
        check("fine clr", trimCode[0], 1'b0);
        $display("Test trim done");
        axiWrite(OFF_CTRL1, 8'h46);
        waitStatus(stExp(1'b1, SRC_INT, 1'b0, 1'b0));
        waitMode(MODE_BYP_INT);
        check("byp int", {mainSel, loopEn, dbgEn}, 4'b0111);
        axiWrite(OFF_CTRL2, 8'h08);
        waitMode(MODE_BYP_INT_LP);
        check("byp int lp", {mainSel, loopEn, dbgEn}, 4'b0100);
        dbg <= 1'b1;
        waitMode(MODE_BYP_INT);
        dbg <= 1'b0;
        axiWrite(OFF_CTRL2, 8'h0E);
        waitStatus(stExp(1'b1, SRC_INT, 1'b1, 1'b0));
        axiWrite(OFF_CTRL1, 8'h83);
        waitStatus(stExp(1'b0, SRC_EXT, 1'b1, 1'b0));
        waitMode(MODE_BYP_EXT_LP);
        check("byp ext lp", {mainSel, loopEn, loopRefInt}, 4'b1000);
        axiWrite(OFF_CTRL2, 8'h07);
        waitMode(MODE_BYP_EXT);
        check("byp ext", {mainSel, loopEn, dbgEn}, 4'b1011);
        $display("Test modes done");
        stopReq <= 1'b1;
        waitMode(MODE_STOP);
        check("stop keep", {mainEn, intEn, extEn}, 3'b011);
        axiWrite(OFF_CTRL2, 8'h05);
        axiWrite(OFF_CTRL1, 8'h82);
        waitStatus(stExp(1'b0, SRC_EXT, 1'b0, 1'b0));
        check("stop drop", {mainEn, intEn, extEn}, 3'b000);
        stopReq <= 1'b0;
        waitMode(MODE_BYP_EXT);
        axiWrite(OFF_CTRL1, 8'hF2);
        waitMode(MODE_ENG_EXT);
        check("ee", {mainSel, loopEn, loopRefInt, refDiv}, 7'h16);
        $display("Test stop done");
        complete_run();
    end
endmodule // icm_clock_mode_ctrl_tb
`default_nettype wire
